// >>> sepf_pkg.sv
// Shared constants for the serial EEPROM pin front end
package sepf_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int BYTE_BITS      = 8;
	localparam int MEM_BYTES      = 512;
	localparam int MEM_ADDR_W     = 9;
	localparam int FIFO_DEPTH     = 32;
	localparam int BIT_CNT_W      = 3;
	localparam int NV_BITS        = 3;

	// ----------------------------------------
	// Clock
	// ----------------------------------------
	localparam int CLK_PERIOD_PS  = 4000;

	// ----------------------------------------
	// Field positions of the non-volatile bits
	// ----------------------------------------
	localparam int NV_SWD_POS     = 2;
	localparam int NV_BPH_POS     = 1;
	localparam int NV_BPL_POS     = 0;

	// ----------------------------------------
	// Reset and power-up values
	// ----------------------------------------
	localparam logic       RST_WEL     = 1'b0;
	localparam logic       RST_WIP     = 1'b0;
	localparam logic [2:0] NV_FACTORY  = 3'h0;
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;
	// Synchroniser reset {sclk, cs_n, sdi, hold_n, wp_n}: clock idle low, select low, protect on
	localparam logic [4:0] PIN_SYNC_RST = 5'h02;

	// ----------------------------------------
	// Link states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SEPF_IDLE,
		SEPF_ACTIVE,
		SEPF_PAUSED
	} sepf_link_e;
endpackage

// >>> sepf_stream_if.sv
// Valid/ready byte stream between the front end and its FIFO
`timescale 1ns/10ps
interface sepf_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> sepf_fifo.sv
// Parameterised synchronous FIFO for received bytes
`timescale 1ns/10ps
module sepf_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Streams
	sepf_stream_if.snk wr,
	sepf_stream_if.src rd
);
	import sepf_pkg::*;

	localparam int AW = $clog2(D);

	logic [W-1:0] store [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	// ----------------------------------------
	// Flags and handshakes
	// ----------------------------------------
	assign wr.ready = (count != (AW+1)'(D));
	assign rd.valid = (count != '0);
	assign rd.data  = store[rd_ptr];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (push) begin
			store[wr_ptr] <= wr.data;
		end
	end

	// ----------------------------------------
	// Pointers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> sepf_frontend.sv
// Serial bus front end of a small byte-wide EEPROM
//
// Notes on behaviour
// RULE1: Array holds 512 bytes, smaller variants fewer.
// RULE2: Output bit changes only after clock fall.
// RULE3: Input bit sampled on each clock rise.
// RULE4: Select high means deselected, output released.
// RULE5: Deselected gives standby unless write running.
// RULE6: Select low makes device selected and active.
// RULE7: Selection needs a falling select edge first.
// RULE8: Pause freezes transfer, keeps place and selection.
// RULE9: Paused: output released, clock and data ignored.
// RULE10: Pause only entered while selected.
// RULE11: Protect low refuses array writes only.
// RULE12: Bus ignored while power-on reset held.
// RULE13: Reset gives standby, idle, latch and busy clear.
// RULE14: Reset keeps write-disable and protect bits.
// RULE15: Master deselects, no write running at power-down.
// RULE16: Bytes shift in and out MSB first.
// RULE17: Pause enters and leaves only while clock low.
// RULE18: Deselect while paused abandons the transfer.
// RULE19: Pause change with clock high waits for low.
`timescale 1ns/10ps
module sepf_frontend #(
	parameter int MEM_DEPTH  = sepf_pkg::MEM_BYTES,
	parameter int RX_DEPTH   = sepf_pkg::FIFO_DEPTH
) (
	// Clock and power-on reset
	input  wire logic                            clk_in,
	input  wire logic                            rst_n_in,
	// Serial pins
	input  wire logic                            sclk_in,
	input  wire logic                            cs_n_in,
	input  wire logic                            sdi_in,
	input  wire logic                            hold_n_in,
	input  wire logic                            wp_n_in,
	output logic                                 sdo_out,
	output logic                                 sdo_oe_out,
	// Received byte stream
	output logic [sepf_pkg::BYTE_BITS-1:0]       rx_data_out,
	output logic                                 rx_valid_out,
	input  wire logic                            rx_ready_in,
	output logic                                 rx_overrun_out,
	// Byte to send
	input  wire logic [sepf_pkg::BYTE_BITS-1:0]  tx_data_in,
	input  wire logic                            tx_valid_in,
	output logic                                 tx_taken_out,
	// Array access from the command logic
	input  wire logic [sepf_pkg::MEM_ADDR_W-1:0] mem_addr_in,
	input  wire logic [sepf_pkg::BYTE_BITS-1:0]  mem_wdata_in,
	input  wire logic                            mem_we_in,
	output logic [sepf_pkg::BYTE_BITS-1:0]       mem_rdata_out,
	output logic                                 write_refused_out,
	// Status bits
	input  wire logic                            wel_set_in,
	input  wire logic                            wel_clr_in,
	input  wire logic                            write_busy_in,
	input  wire logic                            nv_load_in,
	input  wire logic [sepf_pkg::NV_BITS-1:0]    nv_data_in,
	output logic                                 write_enable_latch_out,
	output logic                                 write_in_progress_out,
	output logic                                 status_write_disable_out,
	output logic                                 block_protect_hi_out,
	output logic                                 block_protect_lo_out,
	// Link state
	output logic                                 selected_out,
	output logic                                 paused_out,
	output logic                                 standby_out,
	output logic                                 frame_start_out
);
	import sepf_pkg::*;

	localparam int MA_W = $clog2(MEM_DEPTH);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two stages per pin; only stage two feeds logic
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic       sclk_prev;
	logic       sclk_s;
	logic       cs_n_s;
	logic       sdi_s;
	logic       hold_n_s;
	logic       wp_n_s;
	logic       sclk_rise;
	logic       sclk_fall;

	// Select resets low so the reset value can never arm selection on its own
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_meta  <= PIN_SYNC_RST;
			pin_sync  <= PIN_SYNC_RST;
			sclk_prev <= 1'b0;
		end else begin
			pin_meta  <= {sclk_in, cs_n_in, sdi_in, hold_n_in, wp_n_in};
			pin_sync  <= pin_meta;
			sclk_prev <= pin_sync[4];
		end
	end

	assign sclk_s    = pin_sync[4];
	assign cs_n_s    = pin_sync[3];
	assign sdi_s     = pin_sync[2];
	assign hold_n_s  = pin_sync[1];
	assign wp_n_s    = pin_sync[0];
	assign sclk_rise = sclk_s && !sclk_prev;
	assign sclk_fall = !sclk_s && sclk_prev;

	// ----------------------------------------
	// Select and pause state
	// ----------------------------------------
	// Armed only after select seen high, so a select tied low never starts a frame
	logic       armed;
	sepf_link_e link;
	sepf_link_e next_link;
	logic       shifting;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			armed <= 1'b0; // [RULE12] [RULE13]
		end else if (cs_n_s) begin
			armed <= 1'b1; // [RULE7]
		end
	end

	always_comb begin
		next_link = link;
		case (link)
			SEPF_IDLE: begin
				if (armed && !cs_n_s) begin
					next_link = SEPF_ACTIVE; // [RULE6] [RULE7]
				end
			end
			SEPF_ACTIVE: begin
				if (cs_n_s) begin
					next_link = SEPF_IDLE; // [RULE4]
				end else if (!hold_n_s && !sclk_s) begin
					next_link = SEPF_PAUSED; // [RULE10] [RULE17] [RULE19]
				end
			end
			SEPF_PAUSED: begin
				if (cs_n_s) begin
					next_link = SEPF_IDLE; // [RULE18]
				end else if (hold_n_s && !sclk_s) begin
					next_link = SEPF_ACTIVE; // [RULE17] [RULE19]
				end
			end
			default: begin
				next_link = SEPF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			link <= SEPF_IDLE; // [RULE13]
		end else begin
			link <= next_link;
		end
	end

	// Clock edges count only while actively selected
	assign shifting = (link == SEPF_ACTIVE) && (next_link == SEPF_ACTIVE); // [RULE8] [RULE9]

	// ----------------------------------------
	// Receive shifter
	// ----------------------------------------
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [BYTE_BITS-1:0] rx_shift;
	logic [BYTE_BITS-1:0] rx_hold;
	logic                 rx_pending;
	logic                 byte_done;
	logic                 first_bit;

	sepf_stream_if #(.W(BYTE_BITS)) rx_wr ();
	sepf_stream_if #(.W(BYTE_BITS)) rx_rd ();

	assign byte_done = shifting && sclk_rise && (bit_cnt == BIT_CNT_LAST);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in || link == SEPF_IDLE) begin
			bit_cnt   <= BIT_CNT_ZERO; // [RULE18]
			rx_shift  <= BYTE_ZERO;
			first_bit <= 1'b1;
		end else if (shifting && sclk_rise) begin
			bit_cnt   <= bit_cnt + 1'b1; // [RULE3]
			rx_shift  <= {rx_shift[BYTE_BITS-2:0], sdi_s}; // [RULE16]
			first_bit <= 1'b0;
		end
	end

	// Pending byte stalls here until the FIFO takes it; a second one is an overrun
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_pending     <= 1'b0;
			rx_hold        <= BYTE_ZERO;
			rx_overrun_out <= 1'b0;
		end else begin
			if (byte_done) begin
				rx_hold    <= {rx_shift[BYTE_BITS-2:0], sdi_s}; // [RULE16]
				rx_pending <= 1'b1;
			end else if (rx_wr.ready) begin
				rx_pending <= 1'b0;
			end
			rx_overrun_out <= byte_done && rx_pending && !rx_wr.ready;
		end
	end

	assign rx_wr.valid = rx_pending;
	assign rx_wr.data  = rx_hold;

	sepf_fifo #(
		.W (BYTE_BITS),
		.D (RX_DEPTH)
	) u_rx_fifo (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.wr       (rx_wr),
		.rd       (rx_rd)
	);

	// Registered skid so the stream outputs leave flip-flops
	assign rx_rd.ready = !rx_valid_out || rx_ready_in;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out  <= BYTE_ZERO;
		end else if (rx_rd.ready) begin
			rx_valid_out <= rx_rd.valid;
			rx_data_out  <= rx_rd.data;
		end
	end

	// ----------------------------------------
	// Transmit shifter
	// ----------------------------------------
	logic [BYTE_BITS-1:0] tx_shift;
	logic                 tx_live;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in || link == SEPF_IDLE) begin
			tx_shift     <= BYTE_ZERO;
			tx_live      <= 1'b0;
			tx_taken_out <= 1'b0;
		end else begin
			tx_taken_out <= 1'b0;
			if (shifting && sclk_fall && !first_bit) begin
				if (bit_cnt == BIT_CNT_ZERO) begin
					tx_live      <= tx_valid_in;
					tx_shift     <= tx_valid_in ? tx_data_in : BYTE_ZERO; // [RULE2]
					tx_taken_out <= tx_valid_in;
				end else begin
					tx_shift <= {tx_shift[BYTE_BITS-2:0], 1'b0}; // [RULE16] [RULE2]
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sdo_out    <= 1'b0;
			sdo_oe_out <= 1'b0;
		end else begin
			sdo_out    <= tx_shift[BYTE_BITS-1];
			sdo_oe_out <= tx_live && (link == SEPF_ACTIVE) && !cs_n_s; // [RULE4] [RULE9]
		end
	end

	// ----------------------------------------
	// Link state outputs
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			selected_out    <= 1'b0;
			paused_out      <= 1'b0;
			standby_out     <= 1'b1; // [RULE13]
			frame_start_out <= 1'b0;
		end else begin
			selected_out    <= (next_link != SEPF_IDLE); // [RULE6]
			paused_out      <= (next_link == SEPF_PAUSED); // [RULE8]
			standby_out     <= (next_link == SEPF_IDLE) && !write_busy_in; // [RULE5]
			frame_start_out <= (link == SEPF_IDLE) && (next_link == SEPF_ACTIVE);
		end
	end

	// ----------------------------------------
	// Status bits
	// ----------------------------------------
	// Power-down with a write running is the master's fault; nothing here saves it [RULE15]
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			write_enable_latch_out <= RST_WEL; // [RULE13]
			write_in_progress_out  <= RST_WIP; // [RULE13]
		end else begin
			write_in_progress_out <= write_busy_in;
			if (wel_set_in) begin
				write_enable_latch_out <= 1'b1;
			end else if (wel_clr_in) begin
				write_enable_latch_out <= 1'b0;
			end
		end
	end

	// Non-volatile bits: power-up value models the stored state, reset leaves them alone
	logic [NV_BITS-1:0] nv_bits = NV_FACTORY;

	always_ff @(posedge clk_in) begin
		if (nv_load_in && rst_n_in) begin
			nv_bits <= nv_data_in; // [RULE14]
		end
	end

	assign status_write_disable_out = nv_bits[NV_SWD_POS];
	assign block_protect_hi_out     = nv_bits[NV_BPH_POS];
	assign block_protect_lo_out     = nv_bits[NV_BPL_POS];

	// ----------------------------------------
	// Memory array
	// ----------------------------------------
	// Smaller variants just set MEM_DEPTH; upper address bits are then dropped
	logic [BYTE_BITS-1:0] mem [MEM_DEPTH]; // [RULE1]
	logic [MA_W-1:0]      mem_idx;
	logic                 mem_write_ok;

	assign mem_idx      = mem_addr_in[MA_W-1:0];
	assign mem_write_ok = mem_we_in && wp_n_s && rst_n_in; // [RULE11] [RULE12]

	always_ff @(posedge clk_in) begin
		if (mem_write_ok) begin
			mem[mem_idx] <= mem_wdata_in;
		end
		mem_rdata_out <= mem[mem_idx];
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			write_refused_out <= 1'b0;
		end else begin
			write_refused_out <= mem_we_in && !wp_n_s; // [RULE11]
		end
	end
endmodule

// >>> sepf_frontend_assertions.sv
// Concurrent checks on the front end pins
`timescale 1ns/10ps
module sepf_frontend_assertions (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Pins
	input  wire logic cs_n_in,
	input  wire logic sclk_in,
	input  wire logic hold_n_in,
	input  wire logic wp_n_in,
	input  wire logic mem_we_in,
	input  wire logic write_busy_in,
	// Outputs watched
	input  wire logic sdo_out,
	input  wire logic sdo_oe_out,
	input  wire logic selected_out,
	input  wire logic paused_out,
	input  wire logic standby_out,
	input  wire logic frame_start_out,
	input  wire logic write_refused_out,
	input  wire logic write_enable_latch_out,
	input  wire logic write_in_progress_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Set once select is seen high; margin over the pin synchroniser
	logic seen_hi;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) seen_hi <= 1'b0;
		else if (cs_n_in) seen_hi <= 1'b1;
	end
	sequence desel_s; cs_n_in [*5]; endsequence
	sequence prot_we_s; !wp_n_in [*4] ##0 mem_we_in; endsequence
	sequence hold_rel_s; (hold_n_in && !sclk_in) [*6]; endsequence
	desel_quiet_a: assert property (desel_s |-> !sdo_oe_out && !selected_out && !paused_out)
		else $error("drive or selection while deselected");
	pause_quiet_a: assert property (paused_out [*2] |-> !sdo_oe_out)
		else $error("output driven while paused");
	pause_sel_a: assert property (paused_out |-> selected_out)
		else $error("paused while not selected");
	arm_first_a: assert property (!seen_hi |-> !selected_out)
		else $error("selected without a select edge");
	active_pow_a: assert property ($rose(selected_out) |-> frame_start_out && !standby_out)
		else $error("selection not active");
	busy_active_a: assert property (write_busy_in [*2] |-> !standby_out && write_in_progress_out)
		else $error("standby during write");
	reset_state_a: assert property ($rose(rst_n_in) |-> !selected_out && !paused_out && standby_out
		&& !write_enable_latch_out && !write_in_progress_out)
		else $error("bad state after reset");
	refuse_we_a: assert property (prot_we_s |-> ##[1:2] write_refused_out)
		else $error("protected write not refused");
	pause_exit_a: assert property (hold_rel_s |-> !paused_out)
		else $error("pause held after release");
	sdo_fall_a: assert property ($changed(sdo_out) && sdo_oe_out |-> !sclk_in)
		else $error("output changed with clock high");
endmodule

bind sepf_frontend sepf_frontend_assertions u_sepf_frontend_assertions (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in), .hold_n_in(hold_n_in),
	.wp_n_in(wp_n_in), .mem_we_in(mem_we_in), .write_busy_in(write_busy_in), .sdo_out(sdo_out),
	.sdo_oe_out(sdo_oe_out), .selected_out(selected_out), .paused_out(paused_out), .standby_out(standby_out),
	.frame_start_out(frame_start_out), .write_refused_out(write_refused_out),
	.write_enable_latch_out(write_enable_latch_out), .write_in_progress_out(write_in_progress_out)
);

// >>> sepf_spi_master.sv
// Behavioural serial bus master for the front end
`timescale 1ns/10ps
module sepf_spi_master (
	// Clock and returned data
	input  wire logic clk_in,
	input  wire logic miso_in,
	// Bus pins
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdi_out,
	output logic      hold_n_out
);
	// Clock rests low outside frames
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
		hold_n_out = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Select always falls from a high level, frames end deselected
	task automatic select(input logic sel);
		wait_clk(1);
		cs_n_out <= !sel;
		wait_clk(6);
	endtask
	// 64 ns bit period, MSB first
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sdi_out <= tx[i];
			wait_clk(8);
			sclk_out <= 1'b1;
			rx[i] = miso_in;
			wait_clk(8);
			sclk_out <= 1'b0;
		end
	endtask
	task automatic clk_level(input logic v);
		wait_clk(1);
		sclk_out <= v;
		wait_clk(6);
	endtask
	// Pause only inside a frame, normally with clock low
	task automatic pause(input logic on);
		wait_clk(1);
		hold_n_out <= !on;
		wait_clk(6);
	endtask
endmodule

// >>> tb.sv
// Self-checking bench for the serial front end
`timescale 1ns/10ps
module tb;
	import sepf_pkg::*;
	// ----------------
	// Signals
	// ----------------
	logic       clk_in = 1'b0;
	logic       rst_n_in, wp_n_in, rx_ready_in, tx_valid_in, mem_we_in;
	logic       wel_set_in, wel_clr_in, write_busy_in, nv_load_in;
	logic       sclk_in, cs_n_in, sdi_in, hold_n_in, miso;
	logic [7:0] tx_data_in, mem_wdata_in;
	logic [8:0] mem_addr_in;
	logic [2:0] nv_data_in;
	logic       sdo_out, sdo_oe_out, rx_valid_out, rx_overrun_out, tx_taken_out, write_refused_out;
	logic [7:0] rx_data_out, mem_rdata_out;
	logic       write_enable_latch_out, write_in_progress_out, status_write_disable_out;
	logic       block_protect_hi_out, block_protect_lo_out;
	logic       selected_out, paused_out, standby_out, frame_start_out;
	logic       last_sdo = 1'b0;
	logic       ovr_seen = 1'b0;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         n_taken = 0;

	always #2 clk_in = !clk_in;
	// Released line shows the inverse of its last value
	always @(posedge clk_in) if (sdo_oe_out) last_sdo <= sdo_out;
	always @(posedge clk_in) if (rx_overrun_out === 1'b1) ovr_seen <= 1'b1;
	always @(posedge clk_in) if (tx_taken_out === 1'b1) n_taken <= n_taken + 1;
	assign miso = sdo_oe_out ? sdo_out : !last_sdo;

	sepf_frontend u_sepf_frontend (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in),
		.hold_n_in(hold_n_in), .wp_n_in(wp_n_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
		.rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
		.rx_overrun_out(rx_overrun_out), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
		.tx_taken_out(tx_taken_out), .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in),
		.mem_we_in(mem_we_in), .mem_rdata_out(mem_rdata_out), .write_refused_out(write_refused_out),
		.wel_set_in(wel_set_in), .wel_clr_in(wel_clr_in), .write_busy_in(write_busy_in),
		.nv_load_in(nv_load_in), .nv_data_in(nv_data_in), .write_enable_latch_out(write_enable_latch_out),
		.write_in_progress_out(write_in_progress_out), .status_write_disable_out(status_write_disable_out),
		.block_protect_hi_out(block_protect_hi_out), .block_protect_lo_out(block_protect_lo_out),
		.selected_out(selected_out), .paused_out(paused_out), .standby_out(standby_out),
		.frame_start_out(frame_start_out)
	);
	sepf_spi_master u_sepf_spi_master (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk_in),
		.cs_n_out(cs_n_in), .sdi_out(sdi_in), .hold_n_out(hold_n_in));

	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic pop(input logic [7:0] exp);
		for (int n = 0; n < 64 && rx_valid_out !== 1'b1; n++) @(posedge clk_in);
		chk("rx", {rx_valid_out, rx_data_out}, {1'b1, exp});
		rx_ready_in <= 1'b1;
		@(posedge clk_in);
		rx_ready_in <= 1'b0;
		@(posedge clk_in);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset();
		nv_data_in <= 3'h5;
		nv_load_in <= 1'b1;
		wel_set_in <= 1'b1;
		wel_clr_in <= 1'b1;
		@(posedge clk_in);
		nv_load_in <= 1'b0;
		wel_set_in <= 1'b0;
		wel_clr_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk("wel", write_enable_latch_out, 9'h001);
		wel_clr_in <= 1'b1;
		@(posedge clk_in);
		wel_clr_in <= 1'b0;
		@(posedge clk_in);
		chk("wel clr", write_enable_latch_out, 9'h000);
		wel_set_in <= 1'b1;
		@(posedge clk_in);
		wel_set_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		do_reset();
		chk("nv", {status_write_disable_out, block_protect_hi_out, block_protect_lo_out}, 9'h005);
		chk("state", {selected_out, paused_out, standby_out, write_enable_latch_out, write_in_progress_out,
			sdo_oe_out}, 9'h008);
	endtask
	task automatic t_arm();
		logic [7:0] r;
		rst_n_in <= 1'b0;
		u_sepf_spi_master.select(1'b1);
		u_sepf_spi_master.shift(8'h99, 8, r);
		rst_n_in <= 1'b1;
		u_sepf_spi_master.shift(8'h77, 8, r);
		repeat (8) @(posedge clk_in);
		chk("sel rx", {selected_out, rx_valid_out}, 9'h000);
		u_sepf_spi_master.select(1'b0);
		u_sepf_spi_master.select(1'b1);
		chk("active", {selected_out, standby_out}, 9'h002);
		u_sepf_spi_master.select(1'b0);
		chk("standby", standby_out, 9'h001);
	endtask
	task automatic mem_wr(input logic [7:0] d, input logic prot);
		logic ref_seen;
		ref_seen = 1'b0;
		wp_n_in <= !prot;
		mem_addr_in <= 9'h1FF;
		mem_wdata_in <= d;
		repeat (4) @(posedge clk_in);
		mem_we_in <= 1'b1;
		@(posedge clk_in);
		mem_we_in <= 1'b0;
		repeat (3) begin
			@(posedge clk_in);
			ref_seen |= write_refused_out;
		end
		chk("refused", ref_seen, {8'h00, prot});
		chk("rdata", mem_rdata_out, 9'h06B);
	endtask
	task automatic t_busy();
		write_busy_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk("busy", {standby_out, write_in_progress_out}, 9'h001);
		write_busy_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk("idle", {standby_out, write_in_progress_out}, 9'h002);
	endtask
	// Far side stalls while the buffer overflows; protect low throughout
	task automatic t_fill();
		logic [7:0] r;
		int k;
		int t0;
		t0 = n_taken;
		tx_data_in <= 8'hC3;
		tx_valid_in <= 1'b1;
		u_sepf_spi_master.select(1'b1);
		for (k = 0; k < 36; k++) begin
			u_sepf_spi_master.shift(k[7:0], 8, r);
			if (k > 0) chk("sdo", r, 9'h0C3);
		end
		u_sepf_spi_master.select(1'b0);
		chk("oe ovr", {sdo_oe_out, ovr_seen}, 9'h001);
		chk("taken", 9'(n_taken - t0), 9'h024);
		// Overrun overwrites the pending slot, so the newest byte survives
		for (k = 0; k < 33; k++) pop(k[7:0]);
		pop(8'h23);
		repeat (4) @(posedge clk_in);
		chk("empty", rx_valid_out, 9'h000);
	endtask
	task automatic t_pause();
		logic [7:0] r;
		u_sepf_spi_master.select(1'b1);
		u_sepf_spi_master.shift(8'h11, 8, r);
		u_sepf_spi_master.shift(8'hA0, 4, r);
		u_sepf_spi_master.pause(1'b1);
		chk("pause", {selected_out, paused_out, sdo_oe_out}, 9'h006);
		u_sepf_spi_master.shift(8'hFF, 2, r);
		u_sepf_spi_master.pause(1'b0);
		u_sepf_spi_master.shift(8'h60, 4, r);
		u_sepf_spi_master.select(1'b0);
		pop(8'h11);
		pop(8'hA6);
	endtask
	task automatic t_desel();
		logic [7:0] r;
		u_sepf_spi_master.select(1'b1);
		u_sepf_spi_master.shift(8'hE0, 3, r);
		u_sepf_spi_master.clk_level(1'b1);
		u_sepf_spi_master.pause(1'b1);
		chk("paused", paused_out, 9'h000);
		u_sepf_spi_master.clk_level(1'b0);
		chk("paused", paused_out, 9'h001);
		u_sepf_spi_master.select(1'b0);
		chk("link", {selected_out, paused_out}, 9'h000);
		u_sepf_spi_master.pause(1'b0);
		u_sepf_spi_master.select(1'b1);
		u_sepf_spi_master.shift(8'h5A, 8, r);
		u_sepf_spi_master.select(1'b0);
		pop(8'h5A);
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		final_report();
	end
	initial begin
		rst_n_in <= 1'b0;
		wp_n_in <= 1'b1;
		rx_ready_in <= 1'b0;
		tx_data_in <= 8'h00;
		tx_valid_in <= 1'b0;
		mem_addr_in <= 9'h000;
		mem_wdata_in <= 8'h00;
		mem_we_in <= 1'b0;
		wel_set_in <= 1'b0;
		wel_clr_in <= 1'b0;
		write_busy_in <= 1'b0;
		nv_load_in <= 1'b0;
		nv_data_in <= 3'h0;
		do_reset();
		t_reset();
		t_arm();
		mem_wr(8'h6B, 1'b0);
		mem_wr(8'h00, 1'b1);
		t_busy();
		t_fill();
		t_pause();
		t_desel();
		final_report();
	end
endmodule
